//--- src/video_load_detect_power_control_pkg.sv
package video_load_detect_power_control_pkg;

    // Register addresses on the serial bus
    localparam logic [7:0] CFG_ADDR = 8'h00;
    localparam logic [7:0] DET_ADDR = 8'h01;

    // Configuration register fields
    localparam int CFG_PUMP_BIT = 0;
    localparam int CFG_PATH_BIT = 1;
    localparam int CFG_FILTER_BIT = 3;
    localparam int CFG_CLAMP_BIT = 4;
    localparam int CFG_SW1_BIT = 6;
    localparam int CFG_SW2_BIT = 7;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CFG_WMASK = 8'hdb;

    // Load-detect register fields
    localparam int DET_ACP_BIT = 0;
    localparam int DET_ASP_BIT = 1;
    localparam int DET_FLAG_EN_BIT = 3;
    localparam int DET_LOAD_BIT = 7;
    localparam logic [7:0] DET_RESET = 8'h00;
    localparam logic [7:0] DET_WMASK = 8'h0b;

    // Upper five bits of the 7-bit slave address; the two strap bits follow
    localparam logic [4:0] SLAVE_ADDR_BASE = 5'h13;

    // Time base
    localparam int CLK_SYS_HZ = 25_000_000;
    localparam int CYC_PER_US = CLK_SYS_HZ / 1_000_000;
    localparam int PROBE_TIME_US = 1000;
    localparam int PROBE_PERIOD_US = 125_000;
    localparam int DEBOUNCE_TIME_US = 128_000;
    localparam int LINE_TIME_US = 64;
    localparam int PROBE_CYC_DEF = PROBE_TIME_US * CYC_PER_US;
    localparam int PROBE_PERIOD_CYC_DEF = PROBE_PERIOD_US * CYC_PER_US;
    localparam int DEBOUNCE_CYC_DEF = DEBOUNCE_TIME_US * CYC_PER_US;
    localparam int LINE_CYC = LINE_TIME_US * CYC_PER_US;
    localparam int TIMER_W = 22;

    typedef enum logic [2:0] {
        PW_OFF = 3'b001,
        PW_SETTLE = 3'b010,
        PW_ON = 3'b100
    } power_state_e;

    typedef enum logic [3:0] {
        PB_OFF = 4'b0001,
        PB_SLEEP = 4'b0010,
        PB_PROBE = 4'b0100,
        PB_WATCH = 4'b1000
    } probe_state_e;

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_ADDR = 8'h02,
        ST_ACK_ADDR = 8'h04,
        ST_PTR = 8'h08,
        ST_WDATA = 8'h10,
        ST_ACK_W = 8'h20,
        ST_RDATA = 8'h40,
        ST_RACK = 8'h80
    } bus_state_e;

endpackage

//--- src/video_load_detect_power_control.sv
`timescale 1ns/10ps
// What this block does
// R1 - Power-up: shutdown, switches open, path, pump and detection all off.
// R2 - Configuration bit 0 turns the charge pump on.
// R3 - Configuration bit 1 enables the video signal path.
// R4 - Signal path stays off until the charge pump has settled.
// R5 - Both enables together: path waits for pump settle, then switches on.
// R6 - Both enables clear returns to shutdown.
// R7 - Host should set clamp and filter before enabling the path.
// R8 - Configuration bits 6 and 7 close switch one and switch two.
// R9 - Switch bits act at once, whatever pump or path state.
// R10 - Switches in extended range while pump is on, normal otherwise.
// R11 - Load detection runs while either automatic bit is set.
// R12 - Detect register bit 7 reports the debounced load status.
// R13 - With automatic bits and a load, pump and path turn on.
// R14 - A manual enable forces its block on, ignoring its automatic bit.
// R15 - Every load status change is debounced for 128 ms; the code clears the status at once when detection is disabled.
// R16 - Flag pin active only with flag enable and detection enabled.
// R17 - Flag pulls low on each status change, until detect register is read.
// R18 - Asleep without load, probe eight times a second for 1 ms.
// R19 - Probe output rising means no load; staying low means load.
// R20 - While on, no sink current during a line means disconnection.
// R21 - On disconnection, automatic blocks sleep and probing resumes.
// R22 - Detection disabled: flag released and reads create no flag event.
module video_load_detect_power_control
    import video_load_detect_power_control_pkg::*;
#(
    parameter int unsigned PROBE_CYC = PROBE_CYC_DEF,
    parameter int unsigned PROBE_PERIOD_CYC = PROBE_PERIOD_CYC_DEF,
    parameter int unsigned DEBOUNCE_CYC = DEBOUNCE_CYC_DEF
)
(
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_clk_link,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic [1:0] i_dev_addr,
    input wire logic i_pump_settled,
    input wire logic i_probe_high,
    input wire logic i_out_sinking,
    output logic o_charge_pump_on,
    output logic o_signal_path_on,
    output logic o_extended_range,
    output logic o_switch_one_close,
    output logic o_switch_two_close,
    output logic o_sync_tip_clamp_on,
    output logic o_video_filter_on,
    output logic o_probe_pullup_on,
    output logic o_load_detect_on,
    output logic o_load_change_flag_n_out,
    output logic o_load_change_flag_n_oe
);

    // Read mux, used when loading both the first and following read bytes
    function automatic logic [7:0] read_byte(input logic [7:0] a, input logic [7:0] c,
        input logic [7:0] d, input logic ld);
        logic [7:0] r;
        r = 8'h00;
        if (a == CFG_ADDR)
            r = c;
        else if (a == DET_ADDR)
        begin
            r = d;
            r[DET_LOAD_BIT] = ld;
        end
        return r;
    endfunction

    // Link domain
    logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
    logic [1:0] addr_m, addr_s;
    logic load, load_m, load_s; // load itself is driven by the system domain
    bus_state_e bs;
    logic [3:0] cnt;
    logic [7:0] sh, tx, ptr, rb, cfg_link, det_link;
    logic rw, nack, sda_oe, wr_tgl, rd_tgl;
    logic bus_start, bus_stop, scl_rise, scl_fall;

    // Pins and the status level pass two flops before the bus logic reads them
    always_ff @(posedge i_clk_link or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
            addr_m <= 2'h0;
            addr_s <= 2'h0;
            load_m <= 1'b0;
            load_s <= 1'b0;
        end
        else
        begin
            scl_m <= i_scl;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= i_sda;
            sda_s <= sda_m;
            sda_d <= sda_s;
            addr_m <= i_dev_addr;
            addr_s <= addr_m;
            load_m <= load;
            load_s <= load_m;
        end
    end

    // Bus conditions seen on the synchronised lines
    assign bus_start = scl_s && scl_d && sda_d && !sda_s;
    assign bus_stop = scl_s && scl_d && !sda_d && sda_s;
    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign rb = read_byte(ptr, cfg_link, det_link, load_s);
    assign o_sda_out = 1'b0;
    assign o_sda_oe = sda_oe;

    // Serial slave: address, pointer, register writes and reads
    always_ff @(posedge i_clk_link or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            bs <= ST_IDLE;
            cnt <= 4'h0;
            sh <= 8'h00;
            tx <= 8'h00;
            ptr <= 8'h00;
            rw <= 1'b0;
            nack <= 1'b0;
            sda_oe <= 1'b0;
            cfg_link <= CFG_RESET; // R1
            det_link <= DET_RESET; // R1
            wr_tgl <= 1'b0;
            rd_tgl <= 1'b0;
        end
        else if (bus_start)
        begin
            bs <= ST_ADDR;
            cnt <= 4'h0;
            sda_oe <= 1'b0;
        end
        else if (bus_stop)
        begin
            bs <= ST_IDLE;
            sda_oe <= 1'b0;
        end
        else
        begin
            case (bs)
                ST_IDLE:
                begin
                    sda_oe <= 1'b0;
                end
                ST_ADDR, ST_PTR, ST_WDATA:
                begin
                    if (scl_rise)
                    begin
                        sh <= {sh[6:0], sda_s};
                        cnt <= cnt + 4'h1;
                    end
                    else if (scl_fall && cnt == 4'h8)
                    begin
                        cnt <= 4'h0;
                        if (bs == ST_ADDR)
                        begin
                            if (sh[7:1] == {SLAVE_ADDR_BASE, addr_s})
                            begin
                                rw <= sh[0];
                                sda_oe <= 1'b1;
                                bs <= ST_ACK_ADDR;
                            end
                            else
                                bs <= ST_IDLE;
                        end
                        else if (bs == ST_PTR)
                        begin
                            ptr <= sh;
                            sda_oe <= 1'b1;
                            bs <= ST_ACK_W;
                        end
                        else
                        begin
                            if (ptr == CFG_ADDR)
                                cfg_link <= sh & CFG_WMASK; // R2 R3 R8
                            else if (ptr == DET_ADDR)
                                det_link <= sh & DET_WMASK; // R11
                            ptr <= ptr + 8'h01;
                            wr_tgl <= !wr_tgl;
                            sda_oe <= 1'b1;
                            bs <= ST_ACK_W;
                        end
                    end
                end
                ST_ACK_ADDR:
                begin
                    if (scl_fall)
                    begin
                        cnt <= 4'h0;
                        if (rw)
                        begin
                            tx <= rb; // R12
                            sda_oe <= !rb[7];
                            ptr <= ptr + 8'h01;
                            if (ptr == DET_ADDR)
                                rd_tgl <= !rd_tgl; // R17
                            bs <= ST_RDATA;
                        end
                        else
                        begin
                            sda_oe <= 1'b0;
                            bs <= ST_PTR;
                        end
                    end
                end
                ST_ACK_W:
                begin
                    if (scl_fall)
                    begin
                        sda_oe <= 1'b0;
                        cnt <= 4'h0;
                        bs <= ST_WDATA;
                    end
                end
                ST_RDATA:
                begin
                    if (scl_fall)
                    begin
                        if (cnt == 4'h7)
                        begin
                            sda_oe <= 1'b0;
                            bs <= ST_RACK;
                        end
                        else
                        begin
                            tx <= {tx[6:0], 1'b0};
                            sda_oe <= !tx[6];
                            cnt <= cnt + 4'h1;
                        end
                    end
                end
                ST_RACK:
                begin
                    if (scl_rise)
                        nack <= sda_s;
                    else if (scl_fall)
                    begin
                        cnt <= 4'h0;
                        if (nack)
                            bs <= ST_IDLE;
                        else
                        begin
                            tx <= rb; // R12
                            sda_oe <= !rb[7];
                            ptr <= ptr + 8'h01;
                            if (ptr == DET_ADDR)
                                rd_tgl <= !rd_tgl; // R17
                            bs <= ST_RDATA;
                        end
                    end
                end
                default:
                begin
                    bs <= ST_IDLE;
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // System domain
    logic wr_s1, wr_s2, wr_s3, rd_s1, rd_s2, rd_s3;
    logic settled_m, settled_s, probe_m, probe_s, sink_m, sink_s;
    logic [7:0] cfg, det;
    logic det_en, cp_req, sp_req, raw, seen, flag, load_evt, rd_evt;
    logic [TIMER_W-1:0] timer, deb_cnt;
    power_state_e pw;
    probe_state_e pb;

    // Toggles and analog comparator levels pass two flops; third flop finds edges
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            {wr_s1, wr_s2, wr_s3, rd_s1, rd_s2, rd_s3} <= 6'h00;
            {settled_m, settled_s, probe_m, probe_s, sink_m, sink_s} <= 6'h00;
        end
        else
        begin
            wr_s1 <= wr_tgl;
            wr_s2 <= wr_s1;
            wr_s3 <= wr_s2;
            rd_s1 <= rd_tgl;
            rd_s2 <= rd_s1;
            rd_s3 <= rd_s2;
            settled_m <= i_pump_settled;
            settled_s <= settled_m;
            probe_m <= i_probe_high;
            probe_s <= probe_m;
            sink_m <= i_out_sinking;
            sink_s <= sink_m;
        end
    end

    // Register bytes stay still between writes, so one capture per toggle is safe
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            cfg <= CFG_RESET; // R1
            det <= DET_RESET; // R1
        end
        else if (wr_s2 != wr_s3)
        begin
            cfg <= cfg_link;
            det <= det_link;
        end
    end

    assign rd_evt = rd_s2 != rd_s3;
    assign det_en = det[DET_ASP_BIT] || det[DET_ACP_BIT]; // R11
    // Manual enable wins over its automatic bit
    assign cp_req = cfg[CFG_PUMP_BIT] || (det[DET_ACP_BIT] && load); // R2 R13 R14
    assign sp_req = cfg[CFG_PATH_BIT] || (det[DET_ASP_BIT] && load); // R3 R13 R14
    assign load_evt = det_en && raw != load && deb_cnt == TIMER_W'(DEBOUNCE_CYC - 1);

    // Pump sequencing; the path may only follow a settled pump
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            pw <= PW_OFF;
        else
        begin
            case (pw)
                PW_OFF: if (cp_req) pw <= PW_SETTLE;
                PW_SETTLE:
                begin
                    if (!cp_req)
                        pw <= PW_OFF; // R6
                    else if (settled_s)
                        pw <= PW_ON; // R4 R5
                end
                PW_ON: if (!cp_req) pw <= PW_OFF; // R6
                default: pw <= PW_OFF;
            endcase
        end
    end

    // Analog controls, all registered
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_charge_pump_on <= 1'b0;
            o_signal_path_on <= 1'b0;
            o_extended_range <= 1'b0;
            o_switch_one_close <= 1'b0;
            o_switch_two_close <= 1'b0;
            o_sync_tip_clamp_on <= 1'b0;
            o_video_filter_on <= 1'b0;
            o_load_detect_on <= 1'b0;
        end
        else
        begin
            o_charge_pump_on <= cp_req; // R2
            o_signal_path_on <= sp_req && cp_req && pw == PW_ON && settled_s; // R4 R5
            o_extended_range <= cp_req; // R10
            o_switch_one_close <= cfg[CFG_SW1_BIT]; // R8 R9
            o_switch_two_close <= cfg[CFG_SW2_BIT]; // R8 R9
            o_sync_tip_clamp_on <= cfg[CFG_CLAMP_BIT];
            o_video_filter_on <= cfg[CFG_FILTER_BIT];
            o_load_detect_on <= det_en; // R11
        end
    end

    // Probe scheduler while no load, line watch while a load is present
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            pb <= PB_OFF;
            timer <= '0;
            raw <= 1'b0;
            seen <= 1'b0;
        end
        else if (!det_en)
        begin
            pb <= PB_OFF;
            timer <= '0;
            raw <= 1'b0;
            seen <= 1'b0;
        end
        else
        begin
            case (pb)
                PB_OFF:
                begin
                    timer <= '0;
                    pb <= PB_SLEEP;
                end
                PB_SLEEP:
                begin
                    if (load)
                    begin
                        timer <= '0;
                        seen <= 1'b0;
                        pb <= PB_WATCH;
                    end
                    else if (timer == TIMER_W'(PROBE_PERIOD_CYC - PROBE_CYC - 1))
                    begin
                        timer <= '0;
                        pb <= PB_PROBE; // R18
                    end
                    else
                        timer <= timer + TIMER_W'(1);
                end
                PB_PROBE:
                begin
                    if (timer == TIMER_W'(PROBE_CYC - 1))
                    begin
                        raw <= !probe_s; // R19
                        timer <= '0;
                        pb <= PB_SLEEP;
                    end
                    else
                        timer <= timer + TIMER_W'(1);
                end
                PB_WATCH:
                begin
                    // A line with no sink current reads as a disconnected load
                    if (!load)
                    begin
                        timer <= '0;
                        pb <= PB_SLEEP; // R21
                    end
                    else if (timer == TIMER_W'(LINE_CYC - 1))
                    begin
                        raw <= seen || sink_s; // R20
                        seen <= 1'b0;
                        timer <= '0;
                    end
                    else
                    begin
                        seen <= seen || sink_s;
                        timer <= timer + TIMER_W'(1);
                    end
                end
                default: pb <= PB_OFF;
            endcase
        end
    end

    assign o_probe_pullup_on = pb == PB_PROBE; // R18

    // Debounce: raw must disagree for the full time before the status flips
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            load <= 1'b0;
            deb_cnt <= '0;
        end
        else if (!det_en || raw == load)
        begin
            if (!det_en)
                load <= 1'b0; // R22
            deb_cnt <= '0;
        end
        else if (load_evt)
        begin
            load <= raw; // R12 R15
            deb_cnt <= '0;
        end
        else
            deb_cnt <= deb_cnt + TIMER_W'(1); // R15
    end

    // Change flag; a change in the same cycle as a read keeps the flag set
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            flag <= 1'b0;
        else if (!det_en || !det[DET_FLAG_EN_BIT])
            flag <= 1'b0; // R16 R22
        else if (load_evt)
            flag <= 1'b1; // R17
        else if (rd_evt)
            flag <= 1'b0; // R17
    end

    assign o_load_change_flag_n_out = 1'b0;
    assign o_load_change_flag_n_oe = flag;

    property p_path_needs_pump;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        o_signal_path_on |-> o_charge_pump_on && $past(pw) == PW_ON && $past(settled_s);
    endproperty
    a_path_needs_pump: assert property (p_path_needs_pump) else $error("path on without pump"); // R4

    property p_range;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        o_extended_range == o_charge_pump_on;
    endproperty
    a_range: assert property (p_range) else $error("switch range mismatch"); // R10

    property p_switch;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (cfg[CFG_SW1_BIT] && !cfg[CFG_SW2_BIT]) |=> o_switch_one_close && !o_switch_two_close;
    endproperty
    a_switch: assert property (p_switch) else $error("switch not following bit"); // R8

    property p_manual_pump;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        cfg[CFG_PUMP_BIT] |=> o_charge_pump_on;
    endproperty
    a_manual_pump: assert property (p_manual_pump) else $error("manual pump ignored"); // R14

    property p_auto_on;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (load && det[DET_ACP_BIT]) |=> o_charge_pump_on;
    endproperty
    a_auto_on: assert property (p_auto_on) else $error("auto pump not on with load"); // R13

    property p_shutdown;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (!cfg[CFG_PUMP_BIT] && !cfg[CFG_PATH_BIT] && !det_en) [*2]
            |=> !o_charge_pump_on && !o_signal_path_on && pw == PW_OFF;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("no shutdown"); // R6

    property p_debounce;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (load != $past(load)) && $past(det_en) |-> $past(deb_cnt) == TIMER_W'(DEBOUNCE_CYC - 1);
    endproperty
    a_debounce: assert property (p_debounce) else $error("status changed early"); // R15

    property p_probe_len;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        $fell(o_probe_pullup_on) && $past(det_en) |-> $past(timer) == TIMER_W'(PROBE_CYC - 1);
    endproperty
    a_probe_len: assert property (p_probe_len) else $error("probe length wrong"); // R18

    property p_flag_set;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (load != $past(load)) && $past(det_en && det[DET_FLAG_EN_BIT]) |-> o_load_change_flag_n_oe;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set on change"); // R17

    property p_flag_off;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        !$past(det_en) |-> !o_load_change_flag_n_oe;
    endproperty
    a_flag_off: assert property (p_flag_off) else $error("flag active while disabled"); // R22

    property p_read_clears;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (rd_evt && !load_evt) |=> !o_load_change_flag_n_oe;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read left flag set"); // R17

endmodule // video_load_detect_power_control

//--- tb/video_load_detect_power_control_host.sv
`timescale 1ns/10ps
// Serial bus master: drives the clock and only ever pulls the data line low
module video_load_detect_power_control_host
(
    input wire logic i_clk_link,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    int nacks = 0;
    // Idle bus: clock high, data released
    initial
    begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    // Seven link clocks a step stay well clear of the two-flop sync delay
    task automatic q();
        repeat (7) @(posedge i_clk_link);
        #1;
    endtask
    task automatic put(input logic low, input logic c);
        q();
        o_sda_low = low;
        o_scl = c;
    endtask
    // Also serves as repeated start, since data is released while clock is low
    task automatic start();
        put(1'b0, 1'b0);
        put(1'b0, 1'b1);
        put(1'b1, 1'b1);
        put(1'b1, 1'b0);
    endtask
    task automatic stop();
        put(1'b1, 1'b0);
        put(1'b1, 1'b1);
        put(1'b0, 1'b1);
    endtask
    // Eight bits MSB first, then a released ninth bit sampled for the device ack
    task automatic xfer(input logic [7:0] tx, input logic dev_ack, output logic [7:0] rx);
        logic [8:0] b;
        logic [8:0] s;
        b = {tx, 1'b1};
        for (int i = 8; i >= 0; i--)
        begin
            put(~b[i], 1'b0);
            put(~b[i], 1'b1);
            q();
            s[i] = i_sda;
            put(~b[i], 1'b0);
        end
        rx = s[8:1];
        if (dev_ack && s[0] !== 1'b0)
            nacks++;
    endtask
endmodule // video_load_detect_power_control_host

//--- tb/test_video_load_detect_power_control.sv
`timescale 1ns/10ps
// Register traffic through the host model, analog levels driven here
module test_video_load_detect_power_control;
    import video_load_detect_power_control_pkg::*;
    logic clk = 1'b0;
    logic lclk = 1'b0;
    logic nrst = 1'b0;
    logic settled = 1'b0;
    logic probe_hi = 1'b1;
    logic sink = 1'b1;
    logic scl, host_low, sda_oe, flag_oe, pump, path, ext, sw1, sw2, stc, flt, pull, det;
    int miscompares = 0;
    int total_checks = 0;
    // Pulled-up data line; outputs packed so one compare covers many pins
    wire logic sda = ~(host_low | sda_oe);
    wire logic [9:0] outs = {flag_oe, pull, sw2, sw1, det, stc, flt, ext, path, pump};
    // Clocks
    initial
    begin
        forever #20 clk = ~clk;
    end
    initial
    begin
        #7;
        forever #15 lclk = ~lclk;
    end
    video_load_detect_power_control
        #(.PROBE_CYC(20), .PROBE_PERIOD_CYC(100), .DEBOUNCE_CYC(150))
        i_dut (.i_clk_sys(clk), .i_nrst(nrst), .i_clk_link(lclk), .i_scl(scl), .i_sda(sda),
        .o_sda_out(), .o_sda_oe(sda_oe), .i_dev_addr(2'b00), .i_pump_settled(settled),
        .i_probe_high(probe_hi), .i_out_sinking(sink), .o_charge_pump_on(pump),
        .o_signal_path_on(path), .o_extended_range(ext), .o_switch_one_close(sw1),
        .o_switch_two_close(sw2), .o_sync_tip_clamp_on(stc), .o_video_filter_on(flt),
        .o_probe_pullup_on(pull), .o_load_detect_on(det), .o_load_change_flag_n_out(),
        .o_load_change_flag_n_oe(flag_oe));
    video_load_detect_power_control_host i_host (.i_clk_link(lclk), .i_sda(sda),
        .o_scl(scl), .o_sda_low(host_low));
    task chk(input string name, input logic [9:0] seen, input logic [9:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task close_out();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Bounded wait for masked outputs to reach a value
    task wt(input logic [9:0] m, input logic [9:0] v);
        int i;
        for (i = 0; i < 8000 && (outs & m) !== v; i++)
            cyc(1);
        if (i == 8000)
        begin
            miscompares++;
            close_out();
        end
    endtask
    task head(input logic [7:0] a);
        logic [7:0] r;
        i_host.start();
        i_host.xfer(8'h98, 1'b1, r);
        i_host.xfer(a, 1'b1, r);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        head(a);
        i_host.xfer(d, 1'b1, r);
        i_host.stop();
        cyc(8);
    endtask
    // Single-byte read ends with a master not-acknowledge
    task rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] r;
        head(a);
        i_host.start();
        i_host.xfer(8'h99, 1'b1, r);
        i_host.xfer(8'hff, 1'b0, r);
        i_host.stop();
        cyc(8);
        chk("reg", {2'b00, r}, {2'b00, exp});
    endtask
    // Main sequence
    initial
    begin
        cyc(8);
        nrst = 1'b1;
        cyc(4);
        chk("outs", outs, 10'h000);
        rdc(8'h00, 8'h00);
        rdc(8'h01, 8'h00);
        wr(8'h00, 8'h18);
        wr(8'h00, 8'h1b);
        chk("outs", outs, 10'h01d);
        settled = 1'b1;
        cyc(8);
        chk("outs", outs, 10'h01f);
        rdc(8'h00, 8'h1b);
        wr(8'h00, 8'h80);
        chk("outs", outs, 10'h080);
        settled = 1'b0;
        rdc(8'h05, 8'h00);
        wr(8'h01, 8'h0b);
        wt(10'h120, 10'h120);
        cyc(300);
        rdc(8'h01, 8'h0b);
        probe_hi = 1'b0;
        cyc(100);
        chk("early", outs & 10'h201, 10'h000);
        wt(10'h201, 10'h201);
        settled = 1'b1;
        wt(10'h003, 10'h003);
        cyc(50);
        chk("flag", outs & 10'h200, 10'h200);
        rdc(8'h01, 8'h8b);
        cyc(8);
        chk("flag", outs & 10'h200, 10'h000);
        sink = 1'b0;
        probe_hi = 1'b1;
        wt(10'h203, 10'h200);
        settled = 1'b0;
        wt(10'h100, 10'h100);
        rdc(8'h01, 8'h0b);
        wr(8'h00, 8'h41);
        chk("outs", outs & 10'h0c7, 10'h045);
        wr(8'h01, 8'h08);
        rdc(8'h01, 8'h08);
        cyc(8);
        chk("off", outs & 10'h320, 10'h000);
        chk("nack", 10'(i_host.nacks), 10'h000);
        close_out();
    end
    // Cuts a hung run short
    initial
    begin
        #4000000;
        miscompares++;
        close_out();
    end
endmodule // test_video_load_detect_power_control
